// file: frt_pkg.sv
/*
 * Package for the free-running timer with input capture: clock select
 * codes, reload value, sizes and the enumerations shared by the files.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package frt_pkg;

  localparam int FRT_WIDTH = 16;
  localparam logic [15:0] FRT_RELOAD = 16'hfffc;
  localparam logic [15:0] FRT_TOP = 16'hffff;
  // Timer clock select codes
  localparam logic [1:0] FRT_CS_DIV4 = 2'h0;
  localparam logic [1:0] FRT_CS_DIV2 = 2'h1;
  localparam logic [1:0] FRT_CS_DIV8 = 2'h2;
  localparam logic [1:0] FRT_CS_EXT = 2'h3;
  // Prescaler terminal counts (divide minus one)
  localparam logic [2:0] FRT_PRE_DIV2 = 3'h1;
  localparam logic [2:0] FRT_PRE_DIV4 = 3'h3;
  localparam logic [2:0] FRT_PRE_DIV8 = 3'h7;
  // Register access codes on the access port
  localparam logic [2:0] FRT_ACC_NONE = 3'h0;
  localparam logic [2:0] FRT_ACC_CNT_HI_RD = 3'h1;
  localparam logic [2:0] FRT_ACC_CNT_LO_RD = 3'h2;
  localparam logic [2:0] FRT_ACC_ALT_HI_RD = 3'h3;
  localparam logic [2:0] FRT_ACC_ALT_LO_RD = 3'h4;
  localparam logic [2:0] FRT_ACC_CNT_LO_WR = 3'h5;
  localparam logic [2:0] FRT_ACC_ALT_LO_WR = 3'h6;

  // Read-sequence state of the counter views
  typedef enum logic [1:0] {
    FRT_RS_IDLE = 2'b01,
    FRT_RS_HELD = 2'b10
  } frt_rdseq_e;

endpackage : frt_pkg

// file: frt_ext_sync.sv
/*
 * External timer clock edge detector. Samples the pin on the falling edge
 * of CLK, then produces a one-cycle rising-edge-domain tick per active edge.
 * Assumes the pin toggles no faster than a quarter of CLK.
 */
`timescale 1ns/10ps
module frt_ext_sync
  import frt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edge choice
  input wire logic pin,
  input wire logic edge_fall,
  // Event out
  output logic tick
);

  logic neg_s1_r;
  logic pos_s2_r;
  logic pos_s3_r;

  // Reset to the pulled-up idle level, so no false edge after reset
  // R08 falling-edge sampling
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_s1_r <= 1'b1;
    end else begin
      neg_s1_r <= pin;
    end
  end

  // Second stage feeds the third and, with it, the edge compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_s2_r <= 1'b1;
      pos_s3_r <= 1'b1;
    end else begin
      pos_s2_r <= neg_s1_r;
      pos_s3_r <= pos_s2_r;
    end
  end

  // R07 edge polarity select
  always_comb begin
    tick = edge_fall ? (pos_s3_r & ~pos_s2_r) : (pos_s2_r & ~pos_s3_r);
  end

endmodule : frt_ext_sync

// file: frt_capture.sv
/*
 * One input capture channel: edge detect, 16-bit capture register, flag
 * with two-step clear and high-byte read lockout.
 * Assumes capture pins are synchronous to CLK.
 */
`timescale 1ns/10ps
module frt_capture
  import frt_pkg::*;
#(
  parameter int WIDTH = FRT_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  // Pin and configuration
  input wire logic pin,
  input wire logic edge_rise,
  input wire logic enable,
  input wire logic [WIDTH-1:0] count,
  // Software accesses
  input wire logic status_rd,
  input wire logic hi_rd,
  input wire logic lo_acc,
  // State
  output logic [WIDTH-1:0] value_r,
  output logic flag_r
);

  logic pin_d_r;
  logic locked_r;
  logic armed_r;
  logic hit;

  // Idle high like a pulled-up pin: no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_r <= 1'b1;
    end else begin
      pin_d_r <= pin;
    end
  end

  // R22 pin always feeds capture
  always_comb begin
    hit = enable & ~locked_r &
          (edge_rise ? (pin & ~pin_d_r) : (~pin & pin_d_r));
  end

  // R20 high read locks transfers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_r <= 1'b0;
    end else if (hi_rd) begin
      locked_r <= 1'b1;
    end else if (lo_acc) begin
      locked_r <= 1'b0;
    end
  end

  // R16 latch most recent count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= '0;
    end else if (hit) begin
      value_r <= count;
    end
  end

  // R19 status read arms the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (status_rd && flag_r) begin
      armed_r <= 1'b1;
    end else if (lo_acc) begin
      armed_r <= 1'b0;
    end
  end

  // R19 set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (hit) begin
      flag_r <= 1'b1;
    end else if (lo_acc && armed_r) begin
      flag_r <= 1'b0;
    end
  end

endmodule : frt_capture

// file: frt_timer.sv
/*
 * Free-running 16-bit timer with prescaler, external clock, overflow flag,
 * buffered byte reads and two input capture channels.
 * Assumes software accesses arrive as one-cycle strobes on plain ports and
 * the interrupt mask comes from the CPU; inputs are synchronous to CLK.
 * REDUCED drops capture channel two; its value and flag read zero.
 */
// Overview of operation
// R01: Counter clocked by CPU clock divided by 2, 4, 8, or external clock.
// R02: Sixteen-bit up-counter, read as bytes, one step per timer clock.
// R03: Writing counter low or alternate low byte forces count to FFFCh.
// R04: Reset loads FFFCh into counter and alternate view, in all modes.
// R05: Select 00 divides by four, 01 by two, 10 by eight, 11 external.
// R06: External clock used only when both select bits are one.
// R07: Edge select bit picks rising or falling external clock edges.
// R08: External clock events synchronised to falling CPU clock edge.
// R09: External clock needs four CPU falling edges between active edges.
// R10: High-byte read latches low byte until low byte read completes.
// R11: Low read outside a pending sequence returns live low byte.
// R12: Overflow flag sets on wrap from FFFFh to 0000h, every mode.
// R13: Overflow interrupt when flag, enable and unmasked; stays pending.
// R14: Overflow clears after status read then counter low access only.
// R15: Counts in wait; halt freezes count, resumes from held count.
// R16: Capture edge latches count into channel register, sets flag.
// R17: Each capture channel has its own edge select bit.
// R18: One capture interrupt enable for both channels, pending if masked.
// R19: Capture flag clears after status read then capture low access.
// R20: Capture high read blocks transfers and flag until low read.
// R21: In one-pulse or pulse-width mode only capture two works.
// R22: Capture pins always feed the timer, even when driven as outputs.
// R23: Reduced variant lacks capture two; its flags read zero.
`timescale 1ns/10ps
module frt_timer
  import frt_pkg::*;
#(
  parameter bit REDUCED = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Pins
  input wire logic EXT_CLK_PIN,
  input wire logic CAP_IN_ONE,
  input wire logic CAP_IN_TWO,
  // Configuration
  input wire logic [1:0] TIMER_CLOCK_SELECT,
  input wire logic EXT_EDGE_FALLING,
  input wire logic CAP_EDGE_ONE,
  input wire logic CAP_EDGE_TWO,
  input wire logic OVF_IRQ_ENABLE,
  input wire logic CAP_IRQ_ENABLE,
  input wire logic PULSE_MODE,
  input wire logic HALT_MODE,
  input wire logic IRQ_MASKED,
  // Software accesses, one-cycle strobes
  input wire logic [2:0] COUNTER_ACCESS,
  input wire logic STATUS_READ,
  input wire logic CAP_ONE_HIGH_READ,
  input wire logic CAP_ONE_LOW_ACCESS,
  input wire logic CAP_TWO_HIGH_READ,
  input wire logic CAP_TWO_LOW_ACCESS,
  // Read data and state
  output logic [15:0] COUNTER_VALUE,
  output logic [7:0] COUNTER_READ_BYTE,
  output logic [15:0] CAPTURE_ONE,
  output logic [15:0] CAPTURE_TWO,
  output logic OVERFLOW_FLAG,
  output logic CAPTURE_FLAG_ONE,
  output logic CAPTURE_FLAG_TWO,
  output logic OVF_IRQ,
  output logic CAP_IRQ
);

  logic [2:0] pre_r;
  logic [2:0] pre_top;
  logic ext_tick;
  logic step;
  logic force_load;
  logic [15:0] count_r;
  logic [7:0] low_buf_r;
  logic [7:0] rd_byte_r;
  frt_rdseq_e seq_r;
  logic ovf_r;
  logic ovf_armed_r;
  logic wrap;
  logic cap1_flag;
  logic cap2_flag;
  logic [15:0] cap1_val;
  logic [15:0] cap2_val;
  logic ovf_irq_r;
  logic cap_irq_r;

  // R05 select decoding
  function automatic logic [2:0] pre_limit(input logic [1:0] sel);
    unique case (sel)
      FRT_CS_DIV2: pre_limit = FRT_PRE_DIV2;
      FRT_CS_DIV8: pre_limit = FRT_PRE_DIV8;
      default: pre_limit = FRT_PRE_DIV4;
    endcase
  endfunction : pre_limit

  // Access decoding shared by the read sequence and its buffer
  function automatic logic is_hi_read(input logic [2:0] code);
    return (code == FRT_ACC_CNT_HI_RD) || (code == FRT_ACC_ALT_HI_RD);
  endfunction : is_hi_read

  function automatic logic is_lo_read(input logic [2:0] code);
    return (code == FRT_ACC_CNT_LO_RD) || (code == FRT_ACC_ALT_LO_RD);
  endfunction : is_lo_read

  // Only the main view clears overflow; the alternate view never does
  function automatic logic is_cnt_lo_access(input logic [2:0] code);
    return (code == FRT_ACC_CNT_LO_RD) || (code == FRT_ACC_CNT_LO_WR);
  endfunction : is_cnt_lo_access

  always_comb begin
    pre_top = pre_limit(TIMER_CLOCK_SELECT);
  end

  frt_ext_sync u_ext (
    .clk(CLK),
    .rst_n(RST_N),
    .pin(EXT_CLK_PIN),
    .edge_fall(EXT_EDGE_FALLING),
    .tick(ext_tick)
  );

  // R01 prescaler; halt freezes it too
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_r <= '0;
    end else if (!HALT_MODE) begin
      pre_r <= (pre_r >= pre_top) ? 3'h0 : pre_r + 3'h1;
    end
  end

  // R06 external only for select 11
  // R15 halt stops stepping
  // Wait mode needs nothing: only halt gates stepping
  always_comb begin
    if (HALT_MODE) begin
      step = 1'b0;
    end else if (TIMER_CLOCK_SELECT == FRT_CS_EXT) begin
      step = ext_tick;
    end else begin
      step = (pre_r >= pre_top);
    end
  end

  // R03 low byte writes reload
  always_comb begin
    force_load = (COUNTER_ACCESS == FRT_ACC_CNT_LO_WR) ||
                 (COUNTER_ACCESS == FRT_ACC_ALT_LO_WR);
  end

  // R12 a reload in the same cycle is not a wrap
  always_comb begin
    wrap = step && !force_load && (count_r == FRT_TOP);
  end

  // R02 up-counter
  // R04 reset value FFFCh
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_r <= FRT_RELOAD;
    end else if (force_load) begin
      count_r <= FRT_RELOAD;
    end else if (step) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // R10 high read opens the sequence
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      seq_r <= FRT_RS_IDLE;
    end else begin
      unique case (seq_r)
        FRT_RS_IDLE: begin
          if (is_hi_read(COUNTER_ACCESS)) begin
            seq_r <= FRT_RS_HELD;
          end
        end
        FRT_RS_HELD: begin
          if (is_lo_read(COUNTER_ACCESS)) begin
            seq_r <= FRT_RS_IDLE;
          end
        end
      endcase
    end
  end

  // R10 repeated high reads keep the first buffer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_buf_r <= '0;
    end else if (is_hi_read(COUNTER_ACCESS) && seq_r == FRT_RS_IDLE) begin
      low_buf_r <= count_r[7:0];
    end
  end

  // R11 live low byte when idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_byte_r <= '0;
    end else begin
      unique case (COUNTER_ACCESS)
        FRT_ACC_CNT_HI_RD, FRT_ACC_ALT_HI_RD: rd_byte_r <= count_r[15:8];
        FRT_ACC_CNT_LO_RD, FRT_ACC_ALT_LO_RD:
          rd_byte_r <= (seq_r == FRT_RS_HELD) ? low_buf_r : count_r[7:0];
        default: rd_byte_r <= rd_byte_r;
      endcase
    end
  end

  // R14 status read arms clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_armed_r <= 1'b0;
    end else if (STATUS_READ && ovf_r) begin
      ovf_armed_r <= 1'b1;
    end else if (is_cnt_lo_access(COUNTER_ACCESS)) begin
      ovf_armed_r <= 1'b0;
    end
  end

  // R12 wrap sets flag, set wins
  // R14 only counter low clears
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_r <= 1'b0;
    end else if (wrap) begin
      ovf_r <= 1'b1;
    end else if (ovf_armed_r && is_cnt_lo_access(COUNTER_ACCESS)) begin
      ovf_r <= 1'b0;
    end
  end

  // R16 R17 channel one, edge from control one
  // R21 channel one idle in pulse modes
  frt_capture #(.WIDTH(FRT_WIDTH)) u_cap1 (
    .clk(CLK),
    .rst_n(RST_N),
    .pin(CAP_IN_ONE),
    .edge_rise(CAP_EDGE_ONE),
    .enable(!PULSE_MODE),
    .count(count_r),
    .status_rd(STATUS_READ),
    .hi_rd(CAP_ONE_HIGH_READ),
    .lo_acc(CAP_ONE_LOW_ACCESS),
    .value_r(cap1_val),
    .flag_r(cap1_flag)
  );

  // R23 reduced variant drops channel two
  generate
    if (REDUCED) begin : g_no_cap2
      assign cap2_val = '0;
      assign cap2_flag = 1'b0;
    end else begin : g_cap2
      frt_capture #(.WIDTH(FRT_WIDTH)) u_cap2 (
        .clk(CLK),
        .rst_n(RST_N),
        .pin(CAP_IN_TWO),
        .edge_rise(CAP_EDGE_TWO),
        .enable(1'b1),
        .count(count_r),
        .status_rd(STATUS_READ),
        .hi_rd(CAP_TWO_HIGH_READ),
        .lo_acc(CAP_TWO_LOW_ACCESS),
        .value_r(cap2_val),
        .flag_r(cap2_flag)
      );
    end
  endgenerate

  // R13 overflow request, pending on flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_irq_r <= 1'b0;
    end else begin
      ovf_irq_r <= ovf_r && OVF_IRQ_ENABLE && !IRQ_MASKED;
    end
  end

  // R18 shared capture enable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_irq_r <= 1'b0;
    end else begin
      cap_irq_r <= (cap1_flag || cap2_flag) && CAP_IRQ_ENABLE &&
                   !IRQ_MASKED;
    end
  end

  // Outputs mirror registers; capture values are already flops
  always_comb begin
    COUNTER_VALUE = count_r;
    COUNTER_READ_BYTE = rd_byte_r;
    CAPTURE_ONE = cap1_val;
    CAPTURE_TWO = cap2_val;
    OVERFLOW_FLAG = ovf_r;
    CAPTURE_FLAG_ONE = cap1_flag;
    CAPTURE_FLAG_TWO = cap2_flag;
    OVF_IRQ = ovf_irq_r;
    CAP_IRQ = cap_irq_r;
  end

endmodule : frt_timer

// file: frt_timer_chk.sv
/* Port checker for frt_timer: reload, stepping, halt, flags, requests.
   Assumes it is bound to frt_timer by the statement at its foot. */
`timescale 1ns/10ps
module frt_timer_chk
  import frt_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Controls
  input wire logic [2:0] COUNTER_ACCESS,
  input wire logic HALT_MODE,
  input wire logic OVF_IRQ_ENABLE,
  input wire logic CAP_IRQ_ENABLE,
  input wire logic IRQ_MASKED,
  // State
  input wire logic [15:0] COUNTER_VALUE,
  input wire logic OVERFLOW_FLAG,
  input wire logic CAPTURE_FLAG_ONE,
  input wire logic OVF_IRQ,
  input wire logic CAP_IRQ
);
  logic wr;
  logic clr;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  assign wr = COUNTER_ACCESS inside {FRT_ACC_CNT_LO_WR, FRT_ACC_ALT_LO_WR};
  assign clr = COUNTER_ACCESS inside {FRT_ACC_CNT_LO_RD, FRT_ACC_CNT_LO_WR};
  a_write_reload: assert property (wr |=> COUNTER_VALUE == FRT_RELOAD)
    else $error("no reload after low write");
  a_count_step: assert property (!$stable(COUNTER_VALUE) |->
    COUNTER_VALUE == $past(COUNTER_VALUE) + 16'h1 ||
    COUNTER_VALUE == FRT_RELOAD)
    else $error("counter jumped");
  a_halt_hold: assert property (HALT_MODE && !wr |=> $stable(COUNTER_VALUE))
    else $error("counter moved in halt");
  a_ovf_set: assert property ($past(COUNTER_VALUE) == FRT_TOP &&
    COUNTER_VALUE == 16'h0 |-> OVERFLOW_FLAG)
    else $error("wrap without overflow flag");
  a_ovf_hold: assert property (OVERFLOW_FLAG && !clr |=> OVERFLOW_FLAG)
    else $error("overflow flag lost");
  a_ovf_irq: assert property (OVERFLOW_FLAG && OVF_IRQ_ENABLE &&
    !IRQ_MASKED |=> OVF_IRQ)
    else $error("overflow request missing");
  a_ovf_quiet: assert property (!OVERFLOW_FLAG |=> !OVF_IRQ)
    else $error("overflow request without flag");
  a_cap_irq: assert property (CAPTURE_FLAG_ONE && CAP_IRQ_ENABLE &&
    !IRQ_MASKED |=> CAP_IRQ)
    else $error("capture request missing");
  c_wrap: cover property (COUNTER_VALUE == 16'h0 && OVERFLOW_FLAG);
  c_ovf_irq: cover property (OVF_IRQ);
  c_cap_irq: cover property (CAP_IRQ);
endmodule : frt_timer_chk

bind frt_timer frt_timer_chk chk (
  .CLK(CLK), .RST_N(RST_N), .COUNTER_ACCESS(COUNTER_ACCESS),
  .HALT_MODE(HALT_MODE), .OVF_IRQ_ENABLE(OVF_IRQ_ENABLE),
  .CAP_IRQ_ENABLE(CAP_IRQ_ENABLE), .IRQ_MASKED(IRQ_MASKED),
  .COUNTER_VALUE(COUNTER_VALUE), .OVERFLOW_FLAG(OVERFLOW_FLAG),
  .CAPTURE_FLAG_ONE(CAPTURE_FLAG_ONE), .OVF_IRQ(OVF_IRQ), .CAP_IRQ(CAP_IRQ)
);

// file: frt_pins.sv
/* Far-side pin model: external timer clock and two capture inputs.
   Assumes clk is the timer's CPU clock; pins change on its falling edge. */
`timescale 1ns/10ps
module frt_pins (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  // Pins
  output logic ext,
  output logic cap1,
  output logic cap2
);
  logic [2:0] cnt_r;
  // Pins idle high, as a pulled-up input would
  initial begin
    ext = 1'b1;
    cap1 = 1'b1;
    cap2 = 1'b1;
    cnt_r = 3'h0;
  end
  always @(negedge clk) begin
    if (run) begin
      cnt_r <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
      if (cnt_r == 3'h4)
        ext <= ~ext;
    end
  end
  task automatic flip(input bit two);
    @(negedge clk);
    if (two)
      cap2 = ~cap2;
    else
      cap1 = ~cap1;
  endtask : flip
endmodule : frt_pins

// file: frt_timer_bench.sv
/* Bench for frt_timer with the pin model on its far side.
   Assumes frt_pkg, frt_pins and the bound checker are compiled too. */
`timescale 1ns/10ps
module frt_timer_bench
  import frt_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic [1:0] sel = FRT_CS_DIV2;
  logic [2:0] acc = FRT_ACC_NONE;
  logic efall = 1'b0, e1 = 1'b0, e2 = 1'b0, oen = 1'b0, cen = 1'b0;
  logic pulse = 1'b0, halt = 1'b0, mask = 1'b1, srd = 1'b0;
  logic c1h = 1'b0, c1l = 1'b0, c2h = 1'b0, c2l = 1'b0;
  logic ext, p1, p2, ovf, f1, f2, oirq, cirq;
  logic [7:0] rb;
  logic [15:0] cnt, cap1, cap2;
  int failures = 0;
  int cmp_count = 0;
  int nr = 0;
  int nf = 0;

  always #2 clk = ~clk;
  always @(posedge ext) nr++;
  always @(negedge ext) nf++;

  frt_pins pins (.clk(clk), .run(run), .ext(ext), .cap1(p1), .cap2(p2));
  frt_timer dut (
    .CLK(clk), .RST_N(rst_n), .EXT_CLK_PIN(ext), .CAP_IN_ONE(p1),
    .CAP_IN_TWO(p2), .TIMER_CLOCK_SELECT(sel), .EXT_EDGE_FALLING(efall),
    .CAP_EDGE_ONE(e1), .CAP_EDGE_TWO(e2), .OVF_IRQ_ENABLE(oen),
    .CAP_IRQ_ENABLE(cen), .PULSE_MODE(pulse), .HALT_MODE(halt),
    .IRQ_MASKED(mask), .COUNTER_ACCESS(acc), .STATUS_READ(srd),
    .CAP_ONE_HIGH_READ(c1h), .CAP_ONE_LOW_ACCESS(c1l),
    .CAP_TWO_HIGH_READ(c2h), .CAP_TWO_LOW_ACCESS(c2l),
    .COUNTER_VALUE(cnt), .COUNTER_READ_BYTE(rb), .CAPTURE_ONE(cap1),
    .CAPTURE_TWO(cap2), .OVERFLOW_FLAG(ovf), .CAPTURE_FLAG_ONE(f1),
    .CAPTURE_FLAG_TWO(f2), .OVF_IRQ(oirq), .CAP_IRQ(cirq)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic op(input logic [2:0] code);
    cyc(1);
    acc = code;
    cyc(1);
    acc = FRT_ACC_NONE;
    cyc(1);
  endtask : op

  task automatic strobe(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : strobe

  task automatic reach(input logic [15:0] v);
    for (int i = 0; i < 99 && cnt !== v; i++) cyc(1);
    chk(cnt, v);
  endtask : reach

  // Cycles until the count next moves
  task automatic gap(output int n);
    logic [15:0] v;
    v = cnt;
    for (n = 0; n < 20 && cnt === v; n++) cyc(1);
  endtask : gap

  task automatic t_rates();
    int n;
    for (int k = 0; k < 3; k++) begin
      sel = (k == 0) ? FRT_CS_DIV2 : (k == 1) ? FRT_CS_DIV4 : FRT_CS_DIV8;
      gap(n);
      gap(n);
      gap(n);
      chk(16'(n), 16'(2 << k));
    end
    $display("rates done");
  endtask : t_rates

  task automatic t_ovf();
    sel = FRT_CS_DIV2;
    oen = 1'b1;
    strobe(srd);
    op(FRT_ACC_CNT_LO_WR);
    chk(16'(ovf), 16'h0);
    reach(16'h0000);
    chk(16'(ovf), 16'h1);
    cyc(3);
    chk(16'(oirq), 16'h0);
    mask = 1'b0;
    cyc(2);
    chk(16'(oirq), 16'h1);
    strobe(srd);
    op(FRT_ACC_ALT_LO_RD);
    chk(16'(ovf), 16'h1);
    op(FRT_ACC_CNT_LO_RD);
    chk(16'(ovf), 16'h0);
    $display("overflow done");
  endtask : t_ovf

  task automatic t_reads();
    halt = 1'b1;
    op(FRT_ACC_ALT_LO_WR);
    chk(cnt, FRT_RELOAD);
    op(FRT_ACC_ALT_HI_RD);
    chk(16'(rb), 16'h00ff);
    halt = 1'b0;
    reach(16'hfffd);
    halt = 1'b1;
    op(FRT_ACC_CNT_HI_RD);
    op(FRT_ACC_ALT_LO_RD);
    chk(16'(rb), 16'h00fc);
    op(FRT_ACC_CNT_LO_RD);
    chk(16'(rb), 16'h00fd);
    $display("reads done");
  endtask : t_reads

  // Counter halted except while stepping to FFFEh, so every capture value is known
  task automatic t_cap();
    cen = 1'b1;
    pins.flip(1'b0);
    cyc(3);
    chk(cap1, 16'hfffd);
    chk(16'(cirq), 16'h1);
    strobe(c1h);
    op(FRT_ACC_ALT_LO_WR);
    e1 = 1'b1;
    pins.flip(1'b0);
    cyc(3);
    chk(cap1, 16'hfffd);
    strobe(srd);
    strobe(c1l);
    cyc(1);
    chk(16'(f1), 16'h0);
    pulse = 1'b1;
    pins.flip(1'b0);
    pins.flip(1'b0);
    pins.flip(1'b1);
    pins.flip(1'b1);
    cyc(3);
    chk(16'(f1), 16'h0);
    chk(cap2, FRT_RELOAD);
    chk(16'(f2), 16'h1);
    strobe(srd);
    strobe(c2h);
    halt = 1'b0;
    reach(16'hfffe);
    halt = 1'b1;
    e2 = 1'b1;
    pins.flip(1'b1);
    pins.flip(1'b1);
    cyc(3);
    chk(cap2, FRT_RELOAD);
    strobe(c2l);
    cyc(1);
    chk(16'(f2), 16'h0);
    pins.flip(1'b1);
    pins.flip(1'b1);
    cyc(3);
    chk(cap2, 16'hfffe);
    pulse = 1'b0;
    $display("capture done");
  endtask : t_cap

  task automatic t_ext();
    halt = 1'b0;
    sel = FRT_CS_EXT;
    for (int f = 0; f < 2; f++) begin
      efall = 1'(f);
      op(FRT_ACC_CNT_LO_WR);
      nr = 0;
      nf = 0;
      run = 1'b1;
      cyc(60);
      run = 1'b0;
      cyc(8);
      chk(cnt, FRT_RELOAD + 16'(f ? nf : nr));
    end
    $display("external done");
  endtask : t_ext

  // Reset in halt: reload value, flags cleared, counting restarts
  task automatic t_reset();
    sel = FRT_CS_DIV2;
    halt = 1'b1;
    cyc(2);
    rst_n = 1'b0;
    cyc(2);
    chk(cnt, FRT_RELOAD);
    chk(16'(ovf), 16'h0);
    chk(16'(f2), 16'h0);
    rst_n = 1'b1;
    halt = 1'b0;
    cyc(1);
    chk(cnt, FRT_RELOAD);
    cyc(1);
    chk(cnt, 16'hfffd);
    $display("reset done");
  endtask : t_reset

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    failures++;
    complete_run();
  end

  initial begin
    cyc(8);
    chk(cnt, FRT_RELOAD);
    rst_n = 1'b1;
    t_rates();
    t_ovf();
    t_reads();
    t_cap();
    t_ext();
    t_reset();
    complete_run();
  end
endmodule : frt_timer_bench
